// ==== hw/eprom_ctrl.sv ====
// Host controller that sequences an EPROM through read, program, verify,
// identification and standby over its pins.
// Assumes board level shifters turn vpp_high_en and id_high_voltage_en into
// the real high voltages, and that data_lines is a shared bus resolved
// outside from data_out_en.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Verify: select and gate low, pulse high, programming supply applied.
// - After programming, read back and compare the byte.
// - Identification entered by high voltage on identification-select line.
// - In identification, all other address lines except byte select low.
// - Chip select is per-device selector, gate driven by read strobe.
// - Programming: supply raised, select low, byte driven on data lines.
module eprom_ctrl
   import eprom_ctrl_pkg::*;
#(
   parameter int PROG_CYC = PROG_CYC_DEF
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              cmd_valid,
   input  wire logic [2:0]        cmd_code,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_data,
   output logic                   cmd_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   rsp_error,
   output logic [ADDR_W-1:0]      addr_lines,
   output logic                   chip_select_n,
   output logic                   output_gate_n,
   output logic                   program_pulse_n,
   output logic                   vpp_high_en,
   output logic                   id_high_voltage_en,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_out_en,
   input  wire logic [DATA_W-1:0] data_in
);

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_SETUP  = 6'h02,
      ST_PULSE  = 6'h04,
      ST_GATE   = 6'h08,
      ST_SAMPLE = 6'h10,
      ST_FLOAT  = 6'h20
   } state_e;

   function automatic logic odd_parity_ok(input logic [DATA_W-1:0] b);
      odd_parity_ok = ^b;
   endfunction

   state_e            state_ff, nxt_state;
   logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
   logic [2:0]        op_ff, nxt_op;
   logic [DATA_W-1:0] wdata_ff, nxt_wdata;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic              cs_n_ff, nxt_cs_n;
   logic              oe_n_ff, nxt_oe_n;
   logic              pgm_n_ff, nxt_pgm_n;
   logic              vpp_ff, nxt_vpp;
   logic              idv_ff, nxt_idv;
   logic              den_ff, nxt_den;
   logic              rdy_ff, nxt_rdy;
   logic              rv_ff, nxt_rv;
   logic [DATA_W-1:0] rd_ff, nxt_rd;
   logic              rerr_ff, nxt_rerr;
   logic [DATA_W-1:0] din_meta_ff, din_sync_ff;

   // Data pins come from another chip, so they pass two flops first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         din_meta_ff <= '0;
         din_sync_ff <= '0;
      end else begin
         din_meta_ff <= data_in;
         din_sync_ff <= din_meta_ff;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_op    = op_ff;
      nxt_wdata = wdata_ff;
      nxt_addr  = addr_ff;
      nxt_cs_n  = cs_n_ff;
      nxt_oe_n  = oe_n_ff;
      nxt_pgm_n = pgm_n_ff;
      nxt_vpp   = vpp_ff;
      nxt_idv   = idv_ff;
      nxt_den   = den_ff;
      nxt_rdy   = rdy_ff;
      nxt_rv    = 1'b0;
      nxt_rd    = rd_ff;
      nxt_rerr  = rerr_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (cmd_valid && rdy_ff) begin
               nxt_rdy   = 1'b0;
               nxt_op    = cmd_code;
               nxt_wdata = cmd_data;
               nxt_addr  = cmd_addr;
               nxt_cnt   = CNT_W'(CE_LEAD_CYC);
               nxt_oe_n  = 1'b1;
               nxt_pgm_n = 1'b1;
               nxt_cs_n  = 1'b0;
               nxt_state = ST_SETUP;
               unique case (cmd_code)
                  CMD_PROGRAM: begin
                     nxt_vpp = 1'b1;
                     nxt_den = 1'b1;
                  end
                  CMD_VERIFY: begin
                     nxt_vpp = 1'b1;
                  end
                  CMD_ID_MFR, CMD_ID_DEV: begin
                     nxt_idv  = 1'b1;
                     nxt_addr = '0;
                     nxt_addr[ID_BYTE_BIT] = (cmd_code == CMD_ID_DEV);
                  end
                  CMD_STANDBY: begin
                     // Deselect floats the bus whatever the gate does
                     nxt_cs_n  = 1'b1;
                     nxt_state = ST_FLOAT;
                     nxt_cnt   = CNT_W'(DF_CYC);
                  end
                  default: begin
                     nxt_vpp = 1'b0;
                  end
               endcase
            end
         end
         ST_SETUP: begin
            // Chip select leads the gate by access minus gate delay
            if (cnt_ff <= CNT_W'(1)) begin
               if (op_ff == CMD_PROGRAM) begin
                  nxt_pgm_n = 1'b0;
                  nxt_cnt   = CNT_W'(PROG_CYC);
                  nxt_state = ST_PULSE;
               end else begin
                  nxt_oe_n  = 1'b0;
                  nxt_cnt   = CNT_W'(OE_CYC + 2);
                  nxt_state = ST_GATE;
               end
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         ST_PULSE: begin
            if (cnt_ff <= CNT_W'(1)) begin
               nxt_pgm_n = 1'b1;
               nxt_den   = 1'b0;
               // Read back at once, supply still high
               nxt_op    = CMD_VERIFY;
               nxt_cnt   = CNT_W'(DF_CYC);
               nxt_state = ST_SETUP;
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         ST_GATE: begin
            // Two extra cycles cover the input synchroniser
            if (cnt_ff <= CNT_W'(1)) begin
               nxt_state = ST_SAMPLE;
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         ST_SAMPLE: begin
            nxt_rd   = din_sync_ff;
            nxt_rerr = 1'b0;
            if (op_ff == CMD_VERIFY && vpp_ff && den_ff == 1'b0 &&
                wdata_ff != din_sync_ff && state_ff == ST_SAMPLE) begin
               nxt_rerr = 1'b1;
            end
            if ((op_ff == CMD_ID_MFR || op_ff == CMD_ID_DEV) &&
                !odd_parity_ok(din_sync_ff)) begin
               nxt_rerr = 1'b1;
            end
            if (op_ff == CMD_VERIFY && cmd_code != CMD_VERIFY) begin
               nxt_rerr = (wdata_ff != din_sync_ff);
            end
            nxt_rv    = 1'b1;
            nxt_oe_n  = 1'b1;
            nxt_cs_n  = 1'b1;
            nxt_cnt   = CNT_W'(DF_CYC);
            nxt_state = ST_FLOAT;
         end
         ST_FLOAT: begin
            // Drop high voltages only after select is high
            nxt_vpp = 1'b0;
            nxt_idv = 1'b0;
            if (cnt_ff <= CNT_W'(1)) begin
               nxt_rdy   = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= '0;
         op_ff    <= CMD_READ;
         wdata_ff <= '0;
         addr_ff  <= '0;
         cs_n_ff  <= 1'b1;
         oe_n_ff  <= 1'b1;
         pgm_n_ff <= 1'b1;
         vpp_ff   <= 1'b0;
         idv_ff   <= 1'b0;
         den_ff   <= 1'b0;
         rdy_ff   <= 1'b1;
         rv_ff    <= 1'b0;
         rd_ff    <= '0;
         rerr_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         op_ff    <= nxt_op;
         wdata_ff <= nxt_wdata;
         addr_ff  <= nxt_addr;
         cs_n_ff  <= nxt_cs_n;
         oe_n_ff  <= nxt_oe_n;
         pgm_n_ff <= nxt_pgm_n;
         vpp_ff   <= nxt_vpp;
         idv_ff   <= nxt_idv;
         den_ff   <= nxt_den;
         rdy_ff   <= nxt_rdy;
         rv_ff    <= nxt_rv;
         rd_ff    <= nxt_rd;
         rerr_ff  <= nxt_rerr;
      end
   end

   assign cmd_ready          = rdy_ff;
   assign rsp_valid          = rv_ff;
   assign rsp_data           = rd_ff;
   assign rsp_error          = rerr_ff;
   assign addr_lines         = addr_ff;
   assign chip_select_n      = cs_n_ff;
   assign output_gate_n      = oe_n_ff;
   assign program_pulse_n    = pgm_n_ff;
   assign vpp_high_en        = vpp_ff;
   assign id_high_voltage_en = idv_ff;
   assign data_out           = wdata_ff;
   assign data_out_en        = den_ff;

endmodule // eprom_ctrl

`default_nettype wire

// ==== hw/eprom_ctrl_pkg.sv ====
// Constants shared by the EPROM mode-select controller.
// Assumes a 50 MHz system clock and an 8K x 8 parallel EPROM on the pins.
package eprom_ctrl_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 20;
   // Access delays and program pulse width of the slowest speed grade, in ns
   localparam int T_ACC_NS = 250;
   localparam int T_OE_NS = 50;
   localparam int T_DF_NS = 30;
   localparam int T_PROG_PULSE_NS = 100000;
   // Least times round up to whole cycles
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CE_LEAD_CYC = ACC_CYC - OE_CYC;
   localparam int DF_CYC = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CYC_DEF =
      (T_PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // Address bit positions used in identification mode
   localparam int ID_BYTE_BIT = 0;
   localparam int ID_SEL_BIT = 9;
   // Command codes
   localparam logic [2:0] CMD_READ = 3'h0;
   localparam logic [2:0] CMD_PROGRAM = 3'h1;
   localparam logic [2:0] CMD_VERIFY = 3'h2;
   localparam logic [2:0] CMD_ID_MFR = 3'h3;
   localparam logic [2:0] CMD_ID_DEV = 3'h4;
   localparam logic [2:0] CMD_STANDBY = 3'h5;
endpackage

// ==== test/eprom_ctrl_props.sv ====
// Pin and handshake assertions for the EPROM controller.
// Bound into eprom_ctrl below; one clock domain, sync reset.
`timescale 1ns/1ns
`default_nettype none
module eprom_ctrl_props
   import eprom_ctrl_pkg::*;
#(
   parameter int PROG_CYC = PROG_CYC_DEF
) (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              cmd_valid,
   input wire logic [2:0]        cmd_code,
   input wire logic              cmd_ready,
   input wire logic              rsp_valid,
   input wire logic [ADDR_W-1:0] addr_lines,
   input wire logic              chip_select_n,
   input wire logic              output_gate_n,
   input wire logic              program_pulse_n,
   input wire logic              vpp_high_en,
   input wire logic              id_high_voltage_en,
   input wire logic              data_out_en
);
   logic [CNT_W-1:0] sel_ff;
   logic [CNT_W-1:0] pul_ff;
   logic [CNT_W-1:0] nxt_sel;
   logic [CNT_W-1:0] nxt_pul;
   // Cycles spent selected, and cycles the program pulse has been low
   always_comb begin
      nxt_sel = chip_select_n ? 16'h0 : sel_ff + 16'h1;
      nxt_pul = program_pulse_n ? 16'h0 : pul_ff + 16'h1;
   end
   always_ff @(posedge clk) begin
      sel_ff <= sys_rst ? 16'h0 : nxt_sel;
      pul_ff <= sys_rst ? 16'h0 : nxt_pul;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_gate_sel: assert property (!output_gate_n |->
      !chip_select_n && program_pulse_n) else $error("gate without select");
   chk_gate_setup: assert property ($fell(output_gate_n) |->
      sel_ff >= CE_LEAD_CYC) else $error("gate opened too early");
   chk_gate_rsp: assert property ($fell(output_gate_n) |->
      !output_gate_n[*3] ##[1:5] rsp_valid) else $error("gate too short");
   chk_addr_held: assert property (!chip_select_n &&
      !$past(chip_select_n) |-> $stable(addr_lines)) else $error("addr moved");
   chk_id_addr: assert property (id_high_voltage_en &&
      !chip_select_n |-> addr_lines[ADDR_W-1:1] == 12'h000)
      else $error("id address not zero");
   chk_prog_pins: assert property (!program_pulse_n |->
      vpp_high_en && !chip_select_n && data_out_en && !id_high_voltage_en)
      else $error("pulse without program setup");
   chk_no_fight: assert property (data_out_en |-> output_gate_n)
      else $error("host drives while gate open");
   chk_pulse_len: assert property ($rose(program_pulse_n) |->
      pul_ff == PROG_CYC) else $error("pulse length wrong");
   chk_prog_verify: assert property ($rose(program_pulse_n) |->
      ##[1:4] (!output_gate_n && vpp_high_en)) else $error("no read-back");
   chk_take_sel: assert property (cmd_valid && cmd_ready &&
      cmd_code != CMD_STANDBY |=> !cmd_ready && !chip_select_n)
      else $error("command not started");
   chk_id_entry: assert property (cmd_valid && cmd_ready &&
      (cmd_code == CMD_ID_MFR || cmd_code == CMD_ID_DEV) |=>
      id_high_voltage_en && addr_lines[ID_BYTE_BIT] ==
      ($past(cmd_code) == CMD_ID_DEV)) else $error("id entry wrong");
   chk_read_plain: assert property (cmd_valid && cmd_ready &&
      cmd_code == CMD_READ |=> !id_high_voltage_en && !vpp_high_en)
      else $error("read raised high voltage");
   chk_rsp_release: assert property (rsp_valid |->
      (chip_select_n && output_gate_n) ##[1:3] cmd_ready)
      else $error("no release after response");
   cov_prog: cover property ($rose(program_pulse_n));
   cov_id: cover property (id_high_voltage_en && addr_lines[ID_BYTE_BIT]);
   cov_stby: cover property (cmd_valid && cmd_ready && cmd_code == 3'h5);
endmodule // eprom_ctrl_props
bind eprom_ctrl eprom_ctrl_props #(.PROG_CYC(PROG_CYC)) u_props (
   .clk, .sys_rst, .cmd_valid, .cmd_code, .cmd_ready, .rsp_valid,
   .addr_lines, .chip_select_n, .output_gate_n, .program_pulse_n,
   .vpp_high_en, .id_high_voltage_en, .data_out_en);
`default_nettype wire

// ==== test/eprom_dev_model.sv ====
// Behavioural model of the byte-wide EPROM at the controller pins.
// Also resolves the data lines; no pull-ups, so a float reads inverted.
`timescale 1ns/1ns
`default_nettype none
module eprom_dev_model
   import eprom_ctrl_pkg::*;
#(
   parameter logic [7:0] MFR = 8'h02, // Arbitrary value
   parameter logic [7:0] DEV = 8'h07  // Arbitrary value
) (
   input  wire logic [ADDR_W-1:0] addr_lines,
   input  wire logic              chip_select_n,
   input  wire logic              output_gate_n,
   input  wire logic              program_pulse_n,
   input  wire logic              vpp_high_en,
   input  wire logic              id_high_voltage_en,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_out_en,
   output logic      [DATA_W-1:0] data_in
);
   logic [DATA_W-1:0] mem [0:8191];
   logic [DATA_W-1:0] last = 8'h00;
   logic [DATA_W-1:0] dq;
   wire               gate_late;
   wire               drive;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   assign #(T_OE_NS) gate_late = output_gate_n;
   assign drive = !chip_select_n && !output_gate_n && !gate_late;
   // Codes carry odd parity in the top bit
   assign dq = id_high_voltage_en ? (addr_lines[ID_BYTE_BIT] ? DEV : MFR)
             : mem[addr_lines];
   assign data_in = data_out_en ? data_out : drive ? dq : ~last;
   always @(data_out_en, data_out, drive, dq) begin
      if (data_out_en) last = data_out;
      else if (drive) last = dq;
   end
   // Programming only clears bits
   always @(negedge program_pulse_n) begin
      if (vpp_high_en && !chip_select_n && data_out_en)
         mem[addr_lines] = mem[addr_lines] & data_out;
   end
endmodule // eprom_dev_model
`default_nettype wire

// ==== test/tb_eprom_ctrl.sv ====
// Self-checking bench: controller against the device model.
// Assumes the checker binds itself into eprom_ctrl.
`timescale 1ns/1ns
`default_nettype none
module tb_eprom_ctrl import eprom_ctrl_pkg::*;;
   localparam logic [7:0] MFR = 8'h02; // Arbitrary value
   localparam logic [7:0] DEV = 8'h07; // Arbitrary value
   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              cmd_valid = 1'b0;
   logic [2:0]        cmd_code = 3'h0;
   logic [ADDR_W-1:0] cmd_addr = 13'h0000;
   logic [DATA_W-1:0] cmd_data = 8'h00;
   logic              cmd_ready, rsp_valid, rsp_error, chip_select_n;
   logic              output_gate_n, program_pulse_n, vpp_high_en;
   logic              id_high_voltage_en, data_out_en, gerr;
   logic [DATA_W-1:0] rsp_data, data_out, data_in, got;
   logic [ADDR_W-1:0] addr_lines;
   int                err_total = 0;
   int                n_checks = 0;
   eprom_ctrl #(.PROG_CYC(4)) u_dut (.clk, .sys_rst, .cmd_valid, .cmd_code,
      .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_error,
      .addr_lines, .chip_select_n, .output_gate_n, .program_pulse_n,
      .vpp_high_en, .id_high_voltage_en, .data_out, .data_out_en, .data_in);
   eprom_dev_model #(.MFR(MFR), .DEV(DEV)) u_dev (.addr_lines,
      .chip_select_n, .output_gate_n, .program_pulse_n, .vpp_high_en,
      .id_high_voltage_en, .data_out, .data_out_en, .data_in);
   always #10 clk = ~clk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Holds the request until taken, then waits a bounded time
   task automatic op(input logic [2:0] c, input logic [12:0] a,
                     input logic [7:0] d, input logic r);
      int n;
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clk);
      while (cmd_ready !== 1'b1) @(posedge clk);
      cmd_valid <= 1'b0;
      for (n = 0; n < 9999; n++) begin
         @(posedge clk);
         if (r ? rsp_valid === 1'b1 : cmd_ready === 1'b1) break;
      end
      if (n == 9999 || (!r && n > 3)) err_total++;
      got = rsp_data;
      gerr = rsp_error;
   endtask
   task automatic t_read;
      op(CMD_READ, 13'h1FFF, 8'h00, 1'b1);
      cmp(got, 8'hFF);
   endtask
   task automatic t_prog;
      op(CMD_PROGRAM, 13'h0123, 8'h5A, 1'b1);
      cmp({7'h00, gerr}, 8'h00);
      op(CMD_READ, 13'h0123, 8'h00, 1'b1);
      cmp(got, 8'h5A);
      // Cells only clear, so the second byte cannot land
      op(CMD_PROGRAM, 13'h0123, 8'hA5, 1'b1);
      cmp({7'h00, gerr}, 8'h01);
      cmp(got, 8'h00);
   endtask
   task automatic t_verify;
      op(CMD_VERIFY, 13'h0123, 8'h00, 1'b1);
      cmp({7'h00, gerr}, 8'h00);
      op(CMD_VERIFY, 13'h1000, 8'h00, 1'b1);
      cmp({7'h00, gerr}, 8'h01);
   endtask
   task automatic t_id;
      op(CMD_ID_MFR, 13'h1FFF, 8'h00, 1'b1);
      cmp(got, MFR);
      cmp({7'h00, gerr}, 8'h00);
      op(CMD_ID_DEV, 13'h0000, 8'h00, 1'b1);
      cmp(got, DEV);
      cmp({7'h00, gerr}, 8'h00);
   endtask
   task automatic t_standby;
      op(CMD_STANDBY, 13'h0000, 8'h00, 1'b0);
      cmp({7'h00, chip_select_n}, 8'h01);
      op(CMD_READ, 13'h0123, 8'h00, 1'b1);
      cmp(got, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_read;
      t_prog;
      t_verify;
      t_id;
      t_standby;
      report_and_stop;
   end
   initial begin
      #200000;
      err_total++;
      report_and_stop;
   end
endmodule // tb_eprom_ctrl
`default_nettype wire
